// ---- flash_host_cfg.svh ----
// Constants for the flash host controller: widths, timing, bit positions, command codes
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Bus widths
`define FLH_ADDR_W 21
`define FLH_DATA_W 8

// Clock period and pin timing in ns
`define FLH_CLK_NS       40
`define FLH_T_WP_NS      65
`define FLH_T_ACC_NS     150
`define FLH_T_RST_LOW_NS 20000
`define FLH_T_RST_HI_NS  50

// Derived cycle counts, least times rounded up
`define FLH_WP_CYC      ((`FLH_T_WP_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS)
`define FLH_SYNC_CYC    2
`define FLH_ACC_CYC     (((`FLH_T_ACC_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS) + `FLH_SYNC_CYC)
`define FLH_RST_LOW_CYC ((`FLH_T_RST_LOW_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS)
`define FLH_RST_HI_CYC  ((`FLH_T_RST_HI_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS)
`define FLH_CNT_W       10
`define FLH_CYC_CNT_W   4

// Status bit positions on the data bus
`define FLH_POLL_BIT 7
`define FLH_TOG1_BIT 6
`define FLH_TEX_BIT  5
`define FLH_TMR_BIT  3
`define FLH_TOG2_BIT 2

// Command sequence addresses and data codes
`define FLH_UNLOCK_A1 21'h000555
`define FLH_UNLOCK_A2 21'h0002AA
`define FLH_UNLOCK_D1 8'hAA
`define FLH_UNLOCK_D2 8'h55
`define FLH_CODE_PROG 8'hA0
`define FLH_CODE_ERS  8'h80
`define FLH_CODE_SECT 8'h30
`define FLH_CODE_CHIP 8'h10
`define FLH_CODE_SUSP 8'hB0
`define FLH_CODE_RES  8'h30
`define FLH_CODE_RST  8'hF0

`endif

// ---- flash_host_pkg.sv ----
// Types and sequence helpers for the flash host controller
`include "flash_host_cfg.svh"

package flash_host_pkg;

	typedef logic [`FLH_ADDR_W-1:0] addr_t;
	typedef logic [`FLH_DATA_W-1:0] data_t;

	// User commands
	typedef enum logic [3:0] {
		CMD_READ, CMD_PROGRAM, CMD_SECTOR_ERASE, CMD_ADD_SECTOR, CMD_CHIP_ERASE,
		CMD_SUSPEND, CMD_RESUME, CMD_RESET, CMD_POLL, CMD_HW_RESET
	} cmd_t;

	// Sequencer states
	typedef enum logic [3:0] {
		M_IDLE, M_RST_LOW, M_RST_HIGH, M_SEQ, M_ACC1, M_ACC2, M_TIMER,
		M_PRE, M_POST, M_POLL, M_POLL_RE, M_ABORT, M_READ, M_FIN
	} main_state_t;

	// Pin cycle states
	typedef enum logic [2:0] {
		C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ, C_RECOV
	} cyc_state_t;

	// Index of the last write of a command sequence
	function automatic logic [2:0] seq_last(input cmd_t k);
		case (k)
			CMD_PROGRAM:      seq_last = 3'h3;
			CMD_SECTOR_ERASE: seq_last = 3'h5;
			CMD_CHIP_ERASE:   seq_last = 3'h5;
			default:          seq_last = 3'h0;
		endcase
	endfunction

	// Address and data of one write of a command sequence
	function automatic logic [`FLH_ADDR_W+`FLH_DATA_W-1:0] seq_word(input cmd_t k,
		input logic [2:0] s, input addr_t a, input data_t d);
		logic [`FLH_ADDR_W+`FLH_DATA_W-1:0] w;
		w = {a, `FLH_CODE_RST};
		case (k)
			CMD_PROGRAM: begin
				case (s)
					3'h0:    w = {`FLH_UNLOCK_A1, `FLH_UNLOCK_D1};
					3'h1:    w = {`FLH_UNLOCK_A2, `FLH_UNLOCK_D2};
					3'h2:    w = {`FLH_UNLOCK_A1, `FLH_CODE_PROG};
					default: w = {a, d};
				endcase
			end
			CMD_SECTOR_ERASE, CMD_CHIP_ERASE: begin
				case (s)
					3'h0, 3'h3: w = {`FLH_UNLOCK_A1, `FLH_UNLOCK_D1};
					3'h1, 3'h4: w = {`FLH_UNLOCK_A2, `FLH_UNLOCK_D2};
					3'h2:       w = {`FLH_UNLOCK_A1, `FLH_CODE_ERS};
					default:    w = (k == CMD_CHIP_ERASE) ? {`FLH_UNLOCK_A1, `FLH_CODE_CHIP}
					                                      : {a, `FLH_CODE_SECT};
				endcase
			end
			CMD_ADD_SECTOR: w = {a, `FLH_CODE_SECT};
			CMD_SUSPEND:    w = {a, `FLH_CODE_SUSP};
			CMD_RESUME:     w = {a, `FLH_CODE_RES};
			default:        w = {a, `FLH_CODE_RST};
		endcase
		return w;
	endfunction

endpackage

// ---- flash_cyc_if.sv ----
// Carrier between sequencer and pin cycle engine
interface flash_cyc_if;
	logic                  req;
	logic                  write;
	flash_host_pkg::addr_t addr;
	flash_host_pkg::data_t wdata;
	logic                  ack;
	flash_host_pkg::data_t rdata;

	modport ctrl   (output req, write, addr, wdata, input ack, rdata);
	modport engine (input req, write, addr, wdata, output ack, rdata);
endinterface

// ---- flash_bus_cycle.sv ----
// Pin cycle engine: one write or read cycle on the flash pins per request
`include "flash_host_cfg.svh"

module flash_bus_cycle (
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	flash_cyc_if.engine                cyc,
	input  wire flash_host_pkg::data_t flash_data_in,
	output logic [`FLH_ADDR_W-1:0]     flash_addr_out,
	output logic [`FLH_DATA_W-1:0]     flash_data_out,
	output logic                       flash_data_oe_n_out,
	output logic                       flash_chip_select_n_out,
	output logic                       flash_write_strobe_n_out,
	output logic                       flash_output_enable_n_out
);

	flash_host_pkg::cyc_state_t  state_reg, state_next;
	logic [`FLH_CYC_CNT_W-1:0]   cnt_reg, cnt_next;
	flash_host_pkg::addr_t       addr_reg, addr_next;
	flash_host_pkg::data_t       wdata_reg, wdata_next;
	flash_host_pkg::data_t       rdata_reg, rdata_next;
	flash_host_pkg::data_t       din_s1_reg, din_s2_reg;
	logic                        doe_n_reg, doe_n_next;
	logic                        cs_n_reg, cs_n_next;
	logic                        we_n_reg, we_n_next;
	logic                        oe_n_reg, oe_n_next;
	logic                        ack_reg, ack_next;

	assign cyc.ack                   = ack_reg;
	assign cyc.rdata                 = rdata_reg;
	assign flash_addr_out            = addr_reg;
	assign flash_data_out            = wdata_reg;
	assign flash_data_oe_n_out       = doe_n_reg;
	assign flash_chip_select_n_out   = cs_n_reg;
	assign flash_write_strobe_n_out  = we_n_reg;
	assign flash_output_enable_n_out = oe_n_reg;

	// Next pin levels for the current cycle phase
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		addr_next  = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		doe_n_next = doe_n_reg;
		cs_n_next  = cs_n_reg;
		we_n_next  = we_n_reg;
		oe_n_next  = oe_n_reg;
		ack_next   = 1'b0;
		case (state_reg)
			flash_host_pkg::C_IDLE: begin
				if (cyc.req) begin
					addr_next = cyc.addr;
					cs_n_next = 1'b0;
					cnt_next  = '0;
					if (cyc.write) begin
						wdata_next = cyc.wdata;
						doe_n_next = 1'b0;
						state_next = flash_host_pkg::C_SETUP;
					end else begin
						oe_n_next  = 1'b0;
						state_next = flash_host_pkg::C_READ;
					end
				end
			end
			flash_host_pkg::C_SETUP: begin
				we_n_next  = 1'b0;
				state_next = flash_host_pkg::C_PULSE;
			end
			flash_host_pkg::C_PULSE: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == `FLH_CYC_CNT_W'(`FLH_WP_CYC - 1)) begin
					we_n_next  = 1'b1;
					state_next = flash_host_pkg::C_HOLD;
				end
			end
			flash_host_pkg::C_HOLD: begin
				cs_n_next  = 1'b1;
				doe_n_next = 1'b1;
				state_next = flash_host_pkg::C_RECOV;
			end
			flash_host_pkg::C_READ: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == `FLH_CYC_CNT_W'(`FLH_ACC_CYC - 1)) begin
					rdata_next = din_s2_reg;
					cs_n_next  = 1'b1;
					oe_n_next  = 1'b1;
					state_next = flash_host_pkg::C_RECOV;
				end
			end
			flash_host_pkg::C_RECOV: begin
				ack_next   = 1'b1;
				state_next = flash_host_pkg::C_IDLE;
			end
			default: state_next = flash_host_pkg::C_IDLE;
		endcase
	end

	// Registers, plus two-stage sampling of the data pins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_reg  <= flash_host_pkg::C_IDLE;
			cnt_reg    <= '0;
			addr_reg   <= '0;
			wdata_reg  <= '0;
			rdata_reg  <= '0;
			din_s1_reg <= '0;
			din_s2_reg <= '0;
			doe_n_reg  <= 1'b1;
			cs_n_reg   <= 1'b1;
			we_n_reg   <= 1'b1;
			oe_n_reg   <= 1'b1;
			ack_reg    <= 1'b0;
		end else if (ce_in) begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			addr_reg   <= addr_next;
			wdata_reg  <= wdata_next;
			rdata_reg  <= rdata_next;
			din_s1_reg <= flash_data_in;
			din_s2_reg <= din_s1_reg;
			doe_n_reg  <= doe_n_next;
			cs_n_reg   <= cs_n_next;
			we_n_reg   <= we_n_next;
			oe_n_reg   <= oe_n_next;
			ack_reg    <= ack_next;
		end
	end

endmodule

// ---- flash_erase_window_status.sv ----
// Host-side flash controller: command sequences, erase window checks, status polling
`include "flash_host_cfg.svh"

module flash_erase_window_status (
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	input  wire logic                  cmd_valid_in,
	input  wire flash_host_pkg::cmd_t  cmd_in,
	input  wire flash_host_pkg::addr_t addr_in,
	input  wire flash_host_pkg::data_t data_in,
	output logic                       cmd_ready_out,
	output logic                       done_out,
	output logic                       fail_out,
	output logic                       not_accepted_out,
	output logic                       window_open_out,
	output logic                       busy_out,
	output logic [`FLH_DATA_W-1:0]     rd_data_out,
	input  wire flash_host_pkg::data_t flash_data_in,
	input  wire logic                  ready_busy_in,
	output logic [`FLH_ADDR_W-1:0]     flash_addr_out,
	output logic [`FLH_DATA_W-1:0]     flash_data_out,
	output logic                       flash_data_oe_n_out,
	output logic                       flash_chip_select_n_out,
	output logic                       flash_write_strobe_n_out,
	output logic                       flash_output_enable_n_out,
	output logic                       flash_reset_n_out
);

	flash_cyc_if cyc ();

	flash_host_pkg::main_state_t state_reg, state_next;
	flash_host_pkg::cmd_t        kind_reg, kind_next;
	logic [2:0]                  step_reg, step_next;
	logic [`FLH_CNT_W-1:0]       cnt_reg, cnt_next;
	flash_host_pkg::addr_t       addr_reg, addr_next;
	flash_host_pkg::data_t       wdata_reg, wdata_next;
	flash_host_pkg::addr_t       caddr_reg, caddr_next;
	flash_host_pkg::data_t       cdata_reg, cdata_next;
	flash_host_pkg::data_t       rd_reg, rd_next;
	logic                        req_reg, req_next;
	logic                        wr_reg, wr_next;
	logic                        pend_reg, pend_next;
	logic                        tog_reg, tog_next;
	logic                        ready_reg, ready_next;
	logic                        done_reg, done_next;
	logic                        fail_reg, fail_next;
	logic                        nacc_reg, nacc_next;
	logic                        win_reg, win_next;
	logic                        rstn_reg, rstn_next;
	logic                        rb_s1_reg, rb_s2_reg, busy_reg;
	logic                        is_io, io_wr, got, expect_bit;
	flash_host_pkg::addr_t       io_a;
	flash_host_pkg::data_t       io_d;
	flash_host_pkg::data_t       dat;

	assign cyc.req                   = req_reg;
	assign cyc.write                 = wr_reg;
	assign cyc.addr                  = caddr_reg;
	assign cyc.wdata                 = cdata_reg;
	assign cmd_ready_out             = ready_reg;
	assign done_out                  = done_reg;
	assign fail_out                  = fail_reg;
	assign not_accepted_out          = nacc_reg;
	assign window_open_out           = win_reg;
	assign busy_out                  = busy_reg;
	assign rd_data_out               = rd_reg;
	assign flash_reset_n_out         = rstn_reg;

	// Pin cycle engine
	flash_bus_cycle u_flash_bus_cycle (
		.clk_sys_in                (clk_sys_in),
		.rst_in                    (rst_in),
		.ce_in                     (ce_in),
		.cyc                       (cyc.engine),
		.flash_data_in             (flash_data_in),
		.flash_addr_out            (flash_addr_out),
		.flash_data_out            (flash_data_out),
		.flash_data_oe_n_out       (flash_data_oe_n_out),
		.flash_chip_select_n_out   (flash_chip_select_n_out),
		.flash_write_strobe_n_out  (flash_write_strobe_n_out),
		.flash_output_enable_n_out (flash_output_enable_n_out)
	);

	// Pin cycle chosen by the current state
	always_comb begin
		is_io = 1'b1;
		io_wr = 1'b0;
		io_a  = addr_reg; // Status reads stay inside the sector of interest
		io_d  = wdata_reg;
		case (state_reg)
			flash_host_pkg::M_SEQ: begin
				io_wr        = 1'b1;
				{io_a, io_d} = flash_host_pkg::seq_word(kind_reg, step_reg, addr_reg,
				                                         wdata_reg);
			end
			flash_host_pkg::M_ABORT: begin
				io_wr = 1'b1;
				io_d  = `FLH_CODE_RST;
			end
			flash_host_pkg::M_ACC1, flash_host_pkg::M_ACC2, flash_host_pkg::M_TIMER,
			flash_host_pkg::M_PRE, flash_host_pkg::M_POST, flash_host_pkg::M_POLL,
			flash_host_pkg::M_POLL_RE, flash_host_pkg::M_READ: is_io = 1'b1;
			default: is_io = 1'b0;
		endcase
	end

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		kind_next  = kind_reg;
		step_next  = step_reg;
		cnt_next   = cnt_reg;
		addr_next  = addr_reg;
		wdata_next = wdata_reg;
		caddr_next = caddr_reg;
		cdata_next = cdata_reg;
		rd_next    = rd_reg;
		wr_next    = wr_reg;
		pend_next  = pend_reg;
		tog_next   = tog_reg;
		ready_next = 1'b0;
		nacc_next  = nacc_reg;
		win_next   = win_reg;
		fail_next  = fail_reg;
		rstn_next  = rstn_reg;
		req_next   = 1'b0;
		done_next  = 1'b0;
		dat        = cyc.rdata;
		got        = pend_reg && cyc.ack;
		// Program expects true data on the poll bit, erase expects a one
		expect_bit = (kind_reg == flash_host_pkg::CMD_PROGRAM) ? wdata_reg[`FLH_POLL_BIT] : 1'b1;
		if (is_io && !pend_reg) begin
			req_next   = 1'b1;
			pend_next  = 1'b1;
			wr_next    = io_wr;
			caddr_next = io_a;
			cdata_next = io_d;
		end
		if (got) begin
			pend_next = 1'b0;
		end
		case (state_reg)
			flash_host_pkg::M_IDLE: begin
				ready_next = 1'b1;
				if (cmd_valid_in && ready_reg) begin
					ready_next = 1'b0;
					kind_next  = cmd_in;
					addr_next  = addr_in;
					wdata_next = data_in;
					step_next  = 3'h0;
					nacc_next  = 1'b0;
					fail_next  = 1'b0;
					cnt_next   = '0;
					case (cmd_in)
						flash_host_pkg::CMD_HW_RESET: begin
							rstn_next  = 1'b0;
							state_next = flash_host_pkg::M_RST_LOW;
						end
						flash_host_pkg::CMD_READ:       state_next = flash_host_pkg::M_READ;
						flash_host_pkg::CMD_POLL:       state_next = flash_host_pkg::M_POLL;
						flash_host_pkg::CMD_ADD_SECTOR: state_next = flash_host_pkg::M_PRE;
						default:                        state_next = flash_host_pkg::M_SEQ;
					endcase
				end
			end
			flash_host_pkg::M_SEQ: begin
				if (got) begin
					step_next = step_reg + 3'h1;
					if (step_reg == flash_host_pkg::seq_last(kind_reg)) begin
						case (kind_reg)
							flash_host_pkg::CMD_PROGRAM: state_next = flash_host_pkg::M_POLL;
							flash_host_pkg::CMD_CHIP_ERASE: begin
								win_next   = 1'b0; // No acceptance window for chip erase
								state_next = flash_host_pkg::M_POLL;
							end
							flash_host_pkg::CMD_SECTOR_ERASE: state_next = flash_host_pkg::M_ACC1;
							flash_host_pkg::CMD_ADD_SECTOR:   state_next = flash_host_pkg::M_POST;
							default:                          state_next = flash_host_pkg::M_FIN;
						endcase
					end
				end
			end
			// Acceptance check by two toggle-bit reads
			flash_host_pkg::M_ACC1: begin
				if (got) begin
					tog_next   = dat[`FLH_TOG1_BIT];
					state_next = flash_host_pkg::M_ACC2;
				end
			end
			flash_host_pkg::M_ACC2: begin
				if (got) begin
					if (dat[`FLH_TOG1_BIT] != tog_reg) begin
						state_next = flash_host_pkg::M_TIMER;
					end else begin
						nacc_next  = 1'b1;
						fail_next  = 1'b1;
						state_next = flash_host_pkg::M_FIN;
					end
				end
			end
			// Timer bit low means the window is still open
			flash_host_pkg::M_TIMER: begin
				if (got) begin
					win_next   = ~dat[`FLH_TMR_BIT];
					state_next = flash_host_pkg::M_FIN;
				end
			end
			// Check before an added sector; refuse once erase has begun
			flash_host_pkg::M_PRE: begin
				if (got) begin
					if (dat[`FLH_TMR_BIT]) begin
						win_next   = 1'b0;
						nacc_next  = 1'b1;
						fail_next  = 1'b1;
						state_next = flash_host_pkg::M_FIN;
					end else begin
						state_next = flash_host_pkg::M_SEQ;
					end
				end
			end
			// Check after an added sector; the device restarts its window
			flash_host_pkg::M_POST: begin
				if (got) begin
					if (dat[`FLH_TMR_BIT]) begin
						win_next  = 1'b0;
						nacc_next = 1'b1;
					end
					state_next = flash_host_pkg::M_FIN;
				end
			end
			// Data polling until done or timing exceeded
			flash_host_pkg::M_POLL: begin
				if (got) begin
					win_next = 1'b0;
					if (dat[`FLH_POLL_BIT] == expect_bit) begin
						state_next = flash_host_pkg::M_FIN;
					end else if (dat[`FLH_TEX_BIT]) begin
						state_next = flash_host_pkg::M_POLL_RE;
					end
				end
			end
			// Recheck once, since the poll bit may flip as the limit bit rises
			flash_host_pkg::M_POLL_RE: begin
				if (got) begin
					if (dat[`FLH_POLL_BIT] == expect_bit) begin
						state_next = flash_host_pkg::M_FIN;
					end else begin
						state_next = flash_host_pkg::M_ABORT;
					end
				end
			end
			flash_host_pkg::M_ABORT: begin
				if (got) begin
					fail_next  = 1'b1;
					state_next = flash_host_pkg::M_FIN;
				end
			end
			// Plain array read
			flash_host_pkg::M_READ: begin
				if (got) begin
					rd_next    = dat;
					state_next = flash_host_pkg::M_FIN;
				end
			end
			// Reset pin low long enough for standby and for ready
			flash_host_pkg::M_RST_LOW: begin
				cnt_next = cnt_reg + 1'b1;
				win_next = 1'b0;
				if (cnt_reg == `FLH_CNT_W'(`FLH_RST_LOW_CYC - 1)) begin
					rstn_next  = 1'b1;
					cnt_next   = '0;
					state_next = flash_host_pkg::M_RST_HIGH;
				end
			end
			flash_host_pkg::M_RST_HIGH: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == `FLH_CNT_W'(`FLH_RST_HI_CYC - 1)) begin
					state_next = flash_host_pkg::M_FIN;
				end
			end
			flash_host_pkg::M_FIN: begin
				done_next  = 1'b1;
				state_next = flash_host_pkg::M_IDLE;
			end
			default: state_next = flash_host_pkg::M_IDLE;
		endcase
	end

	// Sequencer registers and ready/busy pin synchroniser
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_reg <= flash_host_pkg::M_IDLE;
			kind_reg  <= flash_host_pkg::CMD_READ;
			step_reg  <= 3'h0;
			cnt_reg   <= '0;
			addr_reg  <= '0;
			wdata_reg <= '0;
			caddr_reg <= '0;
			cdata_reg <= '0;
			rd_reg    <= '0;
			req_reg   <= 1'b0;
			wr_reg    <= 1'b0;
			pend_reg  <= 1'b0;
			tog_reg   <= 1'b0;
			ready_reg <= 1'b0;
			done_reg  <= 1'b0;
			fail_reg  <= 1'b0;
			nacc_reg  <= 1'b0;
			win_reg   <= 1'b0;
			rstn_reg  <= 1'b1;
			rb_s1_reg <= 1'b1;
			rb_s2_reg <= 1'b1;
			busy_reg  <= 1'b0;
		end else if (ce_in) begin
			state_reg <= state_next;
			kind_reg  <= kind_next;
			step_reg  <= step_next;
			cnt_reg   <= cnt_next;
			addr_reg  <= addr_next;
			wdata_reg <= wdata_next;
			caddr_reg <= caddr_next;
			cdata_reg <= cdata_next;
			rd_reg    <= rd_next;
			req_reg   <= req_next;
			wr_reg    <= wr_next;
			pend_reg  <= pend_next;
			tog_reg   <= tog_next;
			ready_reg <= ready_next;
			done_reg  <= done_next;
			fail_reg  <= fail_next;
			nacc_reg  <= nacc_next;
			win_reg   <= win_next;
			rstn_reg  <= rstn_next;
			rb_s1_reg <= ready_busy_in;
			rb_s2_reg <= rb_s1_reg;
			busy_reg  <= ~rb_s2_reg;
		end
	end

endmodule

// ---- flash_ews_props.sv ----
// Port checker for the flash host controller
module flash_ews_props (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_ready_out,
	input wire logic done_out,
	input wire logic fail_out,
	input wire logic not_accepted_out,
	input wire logic busy_out,
	input wire logic ready_busy_in,
	input wire logic flash_chip_select_n_out,
	input wire logic flash_write_strobe_n_out,
	input wire logic flash_output_enable_n_out,
	input wire logic flash_data_oe_n_out,
	input wire logic flash_reset_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] low_reg;
	logic [9:0] low_next;
	logic       take;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Length of the current reset pin pulse
	always_comb low_next = flash_reset_n_out ? 10'h000 : low_reg + 10'h001;
	always_ff @(posedge clk_sys_in) low_reg <= rst_in ? 10'h000 : low_next;
	assign take = ce_in && cmd_valid_in && cmd_ready_out;
	a_take_drops_ready: assert property (take |=> !cmd_ready_out)
		else $error("ready held after take");
	a_take_clears_flags: assert property (take |=> !fail_out && !not_accepted_out)
		else $error("flags kept after take");
	a_done_one_cycle: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
	a_strobe_two_cycles: assert property ($fell(flash_write_strobe_n_out) |=>
		!flash_write_strobe_n_out ##1 flash_write_strobe_n_out) else $error("strobe width");
	a_strobe_in_select: assert property (!flash_write_strobe_n_out |->
		!flash_chip_select_n_out && !flash_data_oe_n_out) else $error("strobe unselected");
	a_read_no_fight: assert property (!flash_output_enable_n_out |->
		flash_data_oe_n_out && flash_write_strobe_n_out) else $error("bus fight");
	a_reset_pulse_len: assert property ($rose(flash_reset_n_out) |->
		low_reg >= 10'h1F4) else $error("reset pulse short");
	a_busy_follows: assert property (busy_out == $past(!ready_busy_in, 3))
		else $error("busy not following pin");
	a_reset_blocks: assert property (!flash_reset_n_out |-> !cmd_ready_out)
		else $error("ready during reset pulse");
endmodule
bind flash_erase_window_status flash_ews_props u_flash_ews_props (.clk_sys_in, .rst_in, .ce_in,
	.cmd_valid_in, .cmd_ready_out, .done_out, .fail_out, .not_accepted_out, .busy_out,
	.ready_busy_in, .flash_chip_select_n_out, .flash_write_strobe_n_out,
	.flash_output_enable_n_out, .flash_data_oe_n_out, .flash_reset_n_out);

// ---- flash_dev_model.sv ----
// Behavioural flash device: command decode, erase window, status bits
module flash_dev_model #(
	parameter int WIN_NS = 4000 // Acceptance window, shortened
) (
	input  wire logic [20:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        cs_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        rst_n_in,
	output logic [7:0]       data_out,
	output logic [20:0]      rd_addr_out,
	output logic             rb_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int         mode = 0; // 0 array, 1 program, 2 window, 3 erase
	int         left = 0;
	bit         arm = 0;
	bit         bad = 0; // Program that can never finish
	bit         tgl = 0;
	time        t_open = 0;
	logic [7:0] arr = 8'h3C;
	logic [7:0] q = 8'h00;
	assign data_out = oe_n_in ? ~q : q; // Released bus shows no stale value
	assign rb_out = !(mode == 1 || mode == 3);
	// Command decode on the strobe's rising edge
	always @(posedge we_n_in) if (!cs_n_in) begin
		if (arm) begin
			mode = 1;
			left = 3;
			bad = wdata_in[7] && !arr[7]; // A one over a zero on bit 7 stalls
			arr = wdata_in;
			arm = 0;
		end else if (wdata_in == 8'hA0) arm = 1;
		else if (wdata_in == 8'hF0) mode = 0; // Reset command ends a stalled operation
		else if (wdata_in == 8'h10) begin
			mode = 3;
			left = 4;
		end else if (wdata_in == 8'h30 && mode != 3) begin
			mode = 2;
			t_open = $time;
		end
	end
	// Reset pin aborts the running operation; a pending program arm is kept
	always @(negedge rst_n_in) mode = 0;
	// Status or array byte on each read
	always @(negedge oe_n_in) begin
		if (mode == 2 && $time - t_open >= WIN_NS) begin
			mode = 3;
			left = 4;
		end
		tgl = ~tgl;
		rd_addr_out = addr_in; // Address of the latest read
		if (mode == 1) q = {~arr[7], tgl, bad, 5'h00};
		else if (mode != 0) q = {1'b0, tgl, 2'h0, mode == 3, tgl, 2'h0};
		else q = arr;
		if ((mode == 1 && !bad) || mode == 3) left--;
		if (left == 0 && mode == 3) arr = 8'hFF;
		if (left == 0 && mode != 2) mode = 0;
	end
endmodule

// ---- flash_erase_window_status_tb_top.sv ----
// Testbench: host controller against the behavioural flash
module flash_erase_window_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_sys_in = 1'b0;
	logic                  rst_in = 1'b1;
	logic                  cmd_valid_in = 1'b0;
	flash_host_pkg::cmd_t  cmd_in = flash_host_pkg::CMD_READ;
	flash_host_pkg::addr_t addr_in = 21'h000000;
	flash_host_pkg::data_t data_in = 8'h00;
	logic                  cmd_ready_out, done_out, fail_out, not_accepted_out;
	logic                  window_open_out, busy_out, rb, oe_n, cs_n, we_n, doe_n, rst_n;
	logic [7:0]            rd_data_out, flash_data_out, fdq;
	logic [20:0]           flash_addr_out, rd_a;
	int                    n_fail = 0;
	int                    compares = 0;
	int                    cyc = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	flash_erase_window_status u_flash_erase_window_status (.clk_sys_in, .rst_in, .ce_in(1'b1),
		.cmd_valid_in, .cmd_in, .addr_in, .data_in, .cmd_ready_out, .done_out, .fail_out,
		.not_accepted_out, .window_open_out, .busy_out, .rd_data_out, .flash_data_in(fdq),
		.ready_busy_in(rb), .flash_addr_out, .flash_data_out, .flash_data_oe_n_out(doe_n),
		.flash_chip_select_n_out(cs_n), .flash_write_strobe_n_out(we_n),
		.flash_output_enable_n_out(oe_n), .flash_reset_n_out(rst_n));
	flash_dev_model u_flash_dev_model (.addr_in(flash_addr_out), .wdata_in(flash_data_out),
		.cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .rst_n_in(rst_n), .data_out(fdq),
		.rd_addr_out(rd_a), .rb_out(rb));
	task automatic end_sim();
		if (n_fail == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [20:0] got, input logic [20:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Result flags packed for one compare
	function automatic logic [7:0] st();
		return {5'h00, fail_out, not_accepted_out, window_open_out};
	endfunction
	// One command: hold request until taken, then wait for done
	task automatic run(input flash_host_pkg::cmd_t c, input logic [20:0] a, input logic [7:0] d);
		cmd_in = c;
		addr_in = a;
		data_in = d;
		cmd_valid_in = 1'b1;
		while (cmd_ready_out !== 1'b1) @(posedge clk_sys_in) #1;
		@(posedge clk_sys_in) #1;
		cmd_valid_in = 1'b0;
		while (done_out !== 1'b1) @(posedge clk_sys_in) #1;
		@(posedge clk_sys_in) #1;
	endtask
	// Hang guard
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys_in);
		#1 rst_in = 1'b0;
		run(flash_host_pkg::CMD_READ, 21'h000100, 8'h00);
		chk(rd_data_out, 8'h3C);
		run(flash_host_pkg::CMD_PROGRAM, 21'h000100, 8'h55);
		chk(st(), 8'h00);
		chk(rd_a, 21'h000100);
		run(flash_host_pkg::CMD_READ, 21'h000100, 8'h00);
		chk(rd_data_out, 8'h55);
		run(flash_host_pkg::CMD_PROGRAM, 21'h000100, 8'h80);
		chk(st(), 8'h04);
		run(flash_host_pkg::CMD_SECTOR_ERASE, 21'h010000, 8'h00);
		chk(st(), 8'h01);
		repeat (2) begin
			repeat (30) @(posedge clk_sys_in) #1;
			run(flash_host_pkg::CMD_ADD_SECTOR, 21'h020000, 8'h00);
			chk(st(), 8'h01);
		end
		repeat (120) @(posedge clk_sys_in) #1;
		run(flash_host_pkg::CMD_ADD_SECTOR, 21'h030000, 8'h00);
		chk(st(), 8'h06);
		run(flash_host_pkg::CMD_POLL, 21'h010000, 8'h00);
		chk(st(), 8'h00);
		chk(rd_a, 21'h010000);
		run(flash_host_pkg::CMD_READ, 21'h010000, 8'h00);
		chk(rd_data_out, 8'hFF);
		run(flash_host_pkg::CMD_CHIP_ERASE, 21'h000000, 8'h00);
		chk(st(), 8'h00);
		run(flash_host_pkg::CMD_HW_RESET, 21'h000000, 8'h00);
		run(flash_host_pkg::CMD_READ, 21'h000200, 8'h00);
		chk(rd_data_out, 8'hFF);
		end_sim();
	end
endmodule
